// ---- hw/ntcr_pkg.sv ----
`default_nettype none
package ntcr_pkg;
  // register addresses
  localparam logic [7:0] ADDR_TW0    = 8'h54;
  localparam logic [7:0] ADDR_TW1    = 8'h55;
  localparam logic [7:0] ADDR_TW2    = 8'h56;
  localparam logic [7:0] ADDR_TW3    = 8'h57;
  localparam logic [7:0] ADDR_PHASEH = 8'h58;
  localparam logic [7:0] ADDR_PHASEL = 8'h59;
  localparam logic [7:0] ADDR_MODCTL = 8'h5A;
  // modulator control field positions
  localparam int BIT_BYPASS    = 7;
  localparam int BIT_FRM_ACK   = 5;
  localparam int BIT_FRM_ARM   = 4;
  localparam int BIT_TUNE_ACK  = 3;
  localparam int BIT_TUNE_TRIG = 2;
  localparam int BIT_SIDEBAND  = 0;
  // reset values
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [7:0] RST_MODCTL = 8'h80;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
endpackage
`default_nettype wire

// ---- hw/ntcr_regs.sv ----
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - hold 32-bit tuning word in four bytes, low byte at lowest address
// - tuning byte writes only stage; active word loads on trigger rising edge
// - set tuning update acknowledge once active word loaded from staged value
// - 16-bit signed phase offset, high byte first, applied on oscillator reset
// - bit 7 bypasses oscillator, resets to one; bit 0 selects sideband image
// - after arm rises, reset oscillator on first extended frame strobe
// - set frame reset acknowledge when oscillator reset by frame strobe
module ntcr_regs (
  input  wire logic        CLK,          // 10 MHz device clock
  input  wire logic        RST,          // async reset, active high
  input  wire logic        WR_EN,        // register write strobe, one cycle
  input  wire logic        RD_EN,        // register read strobe, one cycle
  input  wire logic [7:0]  ADDR,         // register address
  input  wire logic [7:0]  WDATA,        // write data
  output logic      [7:0]  RDATA,        // read data, registered
  input  wire logic        FRAME_EXT,    // extended frame strobe detected
  output logic      [31:0] FREQ_WORD,    // active tuning word
  output logic      [15:0] PHASE_OFFSET, // phase applied on oscillator reset
  output logic             NCO_RESET,    // one-cycle oscillator reset pulse
  output logic             BYPASS,       // oscillator and modulator bypass
  output logic             SIDEBAND      // 1 = inverted low-side image
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [31:0] staged;
    logic [31:0] active;
    logic [15:0] phase;
    logic        bypass;
    logic        frm_ack;
    logic        frm_arm;
    logic        frm_pend;
    logic        tune_ack;
    logic        tune_trig;
    logic        sideband;
    logic        nco_rst;
    logic [7:0]  rdata;
  } ntcr_state_t;

  ntcr_state_t st;
  ntcr_state_t next_st;
  logic [7:0]  modctl;

  // control register readback image
  always_comb begin
    modctl = 8'h00;
    modctl[ntcr_pkg::BIT_BYPASS]    = st.bypass;
    modctl[ntcr_pkg::BIT_FRM_ACK]   = st.frm_ack;
    modctl[ntcr_pkg::BIT_FRM_ARM]   = st.frm_arm;
    modctl[ntcr_pkg::BIT_TUNE_ACK]  = st.tune_ack;
    modctl[ntcr_pkg::BIT_TUNE_TRIG] = st.tune_trig;
    modctl[ntcr_pkg::BIT_SIDEBAND]  = st.sideband;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  // acknowledge bits are read-only; hardware set is sticky until reset
  // because no clear path is defined, a host sees each ack stay high
  always_comb begin
    next_st = st;
    next_st.nco_rst = 1'b0;
    if (WR_EN) begin
      unique case (ADDR)
        ntcr_pkg::ADDR_TW0:    next_st.staged[7:0]   = WDATA;
        ntcr_pkg::ADDR_TW1:    next_st.staged[15:8]  = WDATA;
        ntcr_pkg::ADDR_TW2:    next_st.staged[23:16] = WDATA;
        ntcr_pkg::ADDR_TW3:    next_st.staged[31:24] = WDATA;
        ntcr_pkg::ADDR_PHASEH: next_st.phase[15:8]   = WDATA;
        ntcr_pkg::ADDR_PHASEL: next_st.phase[7:0]    = WDATA;
        ntcr_pkg::ADDR_MODCTL: begin
          next_st.bypass    = WDATA[ntcr_pkg::BIT_BYPASS];
          next_st.sideband  = WDATA[ntcr_pkg::BIT_SIDEBAND];
          next_st.tune_trig = WDATA[ntcr_pkg::BIT_TUNE_TRIG];
          next_st.frm_arm   = WDATA[ntcr_pkg::BIT_FRM_ARM];
          // trigger rising edge copies the staged word in the same write
          if (WDATA[ntcr_pkg::BIT_TUNE_TRIG] && !st.tune_trig) begin
            next_st.active   = st.staged;
            next_st.tune_ack = 1'b1;
          end
          // arm on rising edge; clearing the bit also cancels a pending arm
          if (WDATA[ntcr_pkg::BIT_FRM_ARM] && !st.frm_arm) begin
            next_st.frm_pend = 1'b1;
          end else if (!WDATA[ntcr_pkg::BIT_FRM_ARM]) begin
            next_st.frm_pend = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // frame strobe honoured only while armed; it wins over a same-cycle cancel write
    if (st.frm_pend && FRAME_EXT) begin
      next_st.frm_pend = 1'b0;
      next_st.nco_rst  = 1'b1;
      next_st.frm_ack  = 1'b1;
    end
    // registered read data
    if (RD_EN) begin
      unique case (ADDR)
        ntcr_pkg::ADDR_TW0:    next_st.rdata = st.staged[7:0];
        ntcr_pkg::ADDR_TW1:    next_st.rdata = st.staged[15:8];
        ntcr_pkg::ADDR_TW2:    next_st.rdata = st.staged[23:16];
        ntcr_pkg::ADDR_TW3:    next_st.rdata = st.staged[31:24];
        ntcr_pkg::ADDR_PHASEH: next_st.rdata = st.phase[15:8];
        ntcr_pkg::ADDR_PHASEL: next_st.rdata = st.phase[7:0];
        ntcr_pkg::ADDR_MODCTL: next_st.rdata = modctl;
        default:               next_st.rdata = ntcr_pkg::RD_UNMAPPED;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st.staged    <= {4{ntcr_pkg::RST_BYTE}};
      st.active    <= {4{ntcr_pkg::RST_BYTE}};
      st.phase     <= {2{ntcr_pkg::RST_BYTE}};
      st.bypass    <= ntcr_pkg::RST_MODCTL[ntcr_pkg::BIT_BYPASS];
      st.frm_ack   <= 1'b0;
      st.frm_arm   <= 1'b0;
      st.frm_pend  <= 1'b0;
      st.tune_ack  <= 1'b0;
      st.tune_trig <= 1'b0;
      st.sideband  <= ntcr_pkg::RST_MODCTL[ntcr_pkg::BIT_SIDEBAND];
      st.nco_rst   <= 1'b0;
      st.rdata     <= ntcr_pkg::RD_UNMAPPED;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flip-flops
  assign FREQ_WORD    = st.active;
  assign PHASE_OFFSET = st.phase;
  assign NCO_RESET    = st.nco_rst;
  assign BYPASS       = st.bypass;
  assign SIDEBAND     = st.sideband;
  assign RDATA        = st.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  staged_load_a: assert property (@(posedge CLK) disable iff (RST)
    (WR_EN && ADDR == ntcr_pkg::ADDR_MODCTL && WDATA[ntcr_pkg::BIT_TUNE_TRIG]
     && !st.tune_trig) |=> (FREQ_WORD == $past(st.staged)))
    else $error("active word not loaded on trigger edge");

  word_stable_a: assert property (@(posedge CLK) disable iff (RST)
    !(WR_EN && ADDR == ntcr_pkg::ADDR_MODCTL) |=> $stable(FREQ_WORD))
    else $error("active word changed without trigger");

  tune_ack_a: assert property (@(posedge CLK) disable iff (RST)
    $rose(st.tune_ack) |-> (FREQ_WORD == $past(st.staged)))
    else $error("ack set without load");

  byte_order_a: assert property (@(posedge CLK) disable iff (RST)
    (WR_EN && ADDR == ntcr_pkg::ADDR_TW0) |=> (st.staged[7:0] == $past(WDATA)))
    else $error("low tuning byte misplaced");

  phase_high_a: assert property (@(posedge CLK) disable iff (RST)
    (WR_EN && ADDR == ntcr_pkg::ADDR_PHASEH) |=> (PHASE_OFFSET[15:8] == $past(WDATA)))
    else $error("phase high byte misplaced");

  bypass_write_a: assert property (@(posedge CLK) disable iff (RST)
    (WR_EN && ADDR == ntcr_pkg::ADDR_MODCTL) |=>
      (BYPASS == $past(WDATA[ntcr_pkg::BIT_BYPASS])
       && SIDEBAND == $past(WDATA[ntcr_pkg::BIT_SIDEBAND])))
    else $error("control fields not decoded");

  frame_reset_a: assert property (@(posedge CLK) disable iff (RST)
    (st.frm_pend && FRAME_EXT) |=> (NCO_RESET && !st.frm_pend))
    else $error("armed frame strobe did not reset oscillator");

  no_spurious_a: assert property (@(posedge CLK) disable iff (RST)
    !$past(st.frm_pend) |-> !NCO_RESET)
    else $error("oscillator reset without arm");

  frame_ack_a: assert property (@(posedge CLK) disable iff (RST)
    NCO_RESET |-> st.frm_ack)
    else $error("frame reset acknowledge missing");

  ////////////////////////////////////////////////////////////////////////////
  // checks on byte placement, staging and readback

  // each remaining tuning byte lands in its own slice of the staged word
  byte1_place_a: assert property (@(posedge CLK) disable iff (RST)
    (WR_EN && ADDR == ntcr_pkg::ADDR_TW1) |=> (st.staged[15:8] == $past(WDATA)))
    else $error("tuning byte one misplaced");

  // third byte goes to bits 23 down to 16
  byte2_place_a: assert property (@(posedge CLK) disable iff (RST)
    (WR_EN && ADDR == ntcr_pkg::ADDR_TW2) |=> (st.staged[23:16] == $past(WDATA)))
    else $error("tuning byte two misplaced");

  // top byte sits at the highest address
  byte3_place_a: assert property (@(posedge CLK) disable iff (RST)
    (WR_EN && ADDR == ntcr_pkg::ADDR_TW3) |=> (st.staged[31:24] == $past(WDATA)))
    else $error("tuning byte three misplaced");

  // top tuning byte reads back from the staged word, not the active one
  word_read_a: assert property (@(posedge CLK) disable iff (RST)
    (RD_EN && ADDR == ntcr_pkg::ADDR_TW3) |=> (RDATA == $past(st.staged[31:24])))
    else $error("tuning byte readback wrong");

  // staged word only moves on a tuning byte write
  staged_hold_a: assert property (@(posedge CLK) disable iff (RST)
    !(WR_EN && ADDR >= ntcr_pkg::ADDR_TW0 && ADDR <= ntcr_pkg::ADDR_TW3)
      |=> $stable(st.staged))
    else $error("staged word changed without byte write");

  // a control write with the trigger already high must not reload the word
  trigger_held_a: assert property (@(posedge CLK) disable iff (RST)
    (WR_EN && ADDR == ntcr_pkg::ADDR_MODCTL && st.tune_trig) |=> $stable(FREQ_WORD))
    else $error("active word reloaded without rising trigger");

  // stored trigger follows the last control write, so edges are judged against it
  trigger_stored_a: assert property (@(posedge CLK) disable iff (RST)
    (WR_EN && ADDR == ntcr_pkg::ADDR_MODCTL)
      |=> (st.tune_trig == $past(WDATA[ntcr_pkg::BIT_TUNE_TRIG])))
    else $error("trigger bit not stored");

  ////////////////////////////////////////////////////////////////////////////
  // checks on acknowledges, phase, mode and frame reset

  // a rising trigger raises the acknowledge in the same edge as the load
  ack_on_load_a: assert property (@(posedge CLK) disable iff (RST)
    (WR_EN && ADDR == ntcr_pkg::ADDR_MODCTL && WDATA[ntcr_pkg::BIT_TUNE_TRIG]
     && !st.tune_trig) |=> st.tune_ack)
    else $error("tuning acknowledge not set on load");

  // acknowledge is sticky; nothing but reset lowers it
  tune_ack_hold_a: assert property (@(posedge CLK) disable iff (RST)
    st.tune_ack |=> st.tune_ack)
    else $error("tuning acknowledge dropped");

  // the acknowledge cannot rise on any cycle without a control write
  tune_ack_ro_a: assert property (@(posedge CLK) disable iff (RST)
    (!st.tune_ack && !(WR_EN && ADDR == ntcr_pkg::ADDR_MODCTL)) |=> !st.tune_ack)
    else $error("tuning acknowledge set without rising trigger");

  // low phase byte lands in the low half of the offset
  phase_low_a: assert property (@(posedge CLK) disable iff (RST)
    (WR_EN && ADDR == ntcr_pkg::ADDR_PHASEL) |=> (PHASE_OFFSET[7:0] == $past(WDATA)))
    else $error("phase low byte misplaced");

  // offset only changes on a phase byte write
  phase_hold_a: assert property (@(posedge CLK) disable iff (RST)
    !(WR_EN && (ADDR == ntcr_pkg::ADDR_PHASEH || ADDR == ntcr_pkg::ADDR_PHASEL))
      |=> $stable(PHASE_OFFSET))
    else $error("phase offset changed without write");

  // mode outputs only follow control writes
  mode_hold_a: assert property (@(posedge CLK) disable iff (RST)
    !(WR_EN && ADDR == ntcr_pkg::ADDR_MODCTL) |=> ($stable(BYPASS) && $stable(SIDEBAND)))
    else $error("mode changed without control write");

  // control readback shows the live field image
  modctl_read_a: assert property (@(posedge CLK) disable iff (RST)
    (RD_EN && ADDR == ntcr_pkg::ADDR_MODCTL) |=> (RDATA == $past(modctl)))
    else $error("control readback wrong");

  // a rising arm bit leaves a pending request behind
  arm_pending_a: assert property (@(posedge CLK) disable iff (RST)
    (WR_EN && ADDR == ntcr_pkg::ADDR_MODCTL && WDATA[ntcr_pkg::BIT_FRM_ARM]
     && !st.frm_arm) |=> st.frm_pend)
    else $error("arm edge not recorded");

  // clearing the arm bit cancels whatever was pending
  arm_cancel_a: assert property (@(posedge CLK) disable iff (RST)
    (WR_EN && ADDR == ntcr_pkg::ADDR_MODCTL && !WDATA[ntcr_pkg::BIT_FRM_ARM])
      |=> !st.frm_pend)
    else $error("pending arm survived a clear");

  // a pending request always sits under a stored arm bit
  pend_armed_a: assert property (@(posedge CLK) disable iff (RST)
    st.frm_pend |-> st.frm_arm)
    else $error("pending request without arm bit");

  // the oscillator reset is a single-cycle pulse
  reset_pulse_a: assert property (@(posedge CLK) disable iff (RST)
    NCO_RESET |=> !NCO_RESET)
    else $error("oscillator reset longer than one cycle");

  // a strobe with nothing pending is ignored
  unarmed_strobe_a: assert property (@(posedge CLK) disable iff (RST)
    (FRAME_EXT && !st.frm_pend) |=> !NCO_RESET)
    else $error("unarmed strobe reset the oscillator");

  // frame acknowledge only rises together with a reset pulse
  frame_ack_cause_a: assert property (@(posedge CLK) disable iff (RST)
    $rose(st.frm_ack) |-> NCO_RESET)
    else $error("frame acknowledge without reset");

  // frame acknowledge is sticky until reset
  frame_ack_hold_a: assert property (@(posedge CLK) disable iff (RST)
    st.frm_ack |=> st.frm_ack)
    else $error("frame acknowledge dropped");

endmodule
`default_nettype wire

// ---- testbench/ntcr_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module ntcr_host (
  input  wire logic       CLK,   // device clock
  output logic            WR_EN, // write strobe
  output logic            RD_EN, // read strobe
  output logic      [7:0] ADDR,  // register address
  output logic      [7:0] WDATA, // write data
  input  wire logic [7:0] RDATA  // read data
);
  initial begin
    WR_EN = 1'b0;
    RD_EN = 1'b0;
    ADDR  = 8'h00;
    WDATA = 8'h00;
  end
  // one write, strobe held for one taken edge, then one idle edge
  // the idle edge keeps back-to-back calls from lowering and raising in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ADDR = a;
    WDATA = d;
    WR_EN = 1'b1;
    @(posedge CLK);
    #1;
    WR_EN = 1'b0;
    WDATA = ~d; // idle data never repeats the last value
    @(posedge CLK);
    #1;
  endtask
  // read data is taken one edge after the strobe, while it stands
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    ADDR = a;
    RD_EN = 1'b1;
    @(posedge CLK);
    #1;
    RD_EN = 1'b0;
    @(posedge CLK);
    #1;
    d = RDATA;
  endtask
  // all four bytes before the trigger, trigger dropped then raised
  task automatic tune(input logic [31:0] w);
    for (int i = 0; i < 4; i++) begin
      wr(ntcr_pkg::ADDR_TW0 + 8'(i), w[8*i +: 8]);
    end
    wr(ntcr_pkg::ADDR_MODCTL, 8'h00);
    wr(ntcr_pkg::ADDR_MODCTL, 8'h04);
  endtask
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic CLK = 1'b0, RST = 1'b1, FRAME_EXT = 1'b0, WR_EN, RD_EN, NCO_RESET, BYPASS, SIDEBAND;
  logic [7:0] ADDR, WDATA, RDATA, r;
  logic [31:0] FREQ_WORD;
  logic [15:0] PHASE_OFFSET;
  int miscompares = 0, samples_checked = 0, cycles = 0;
  always #50 CLK = ~CLK;
  ntcr_host i_host (.CLK(CLK), .WR_EN(WR_EN), .RD_EN(RD_EN), .ADDR(ADDR), .WDATA(WDATA),
    .RDATA(RDATA));
  ntcr_regs i_dut (.CLK(CLK), .RST(RST), .WR_EN(WR_EN), .RD_EN(RD_EN), .ADDR(ADDR),
    .WDATA(WDATA), .RDATA(RDATA), .FRAME_EXT(FRAME_EXT), .FREQ_WORD(FREQ_WORD),
    .PHASE_OFFSET(PHASE_OFFSET), .NCO_RESET(NCO_RESET), .BYPASS(BYPASS), .SIDEBAND(SIDEBAND));
  ////////////////////////////////////////////////////////////////
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // a hung run ends here; the whole sequence needs about eighty cycles
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic test_reset;
    check("bypass", BYPASS, 1);
    check("sideband", SIDEBAND, 0);
    i_host.rd(ntcr_pkg::ADDR_MODCTL, r);
    check("modctl", r, 8'h80);
    i_host.rd(ntcr_pkg::ADDR_TW0, r);
    check("tw0", r, 8'h00);
    i_host.rd(8'h60, r);
    check("unmapped", r, 8'h00);
  endtask
  task automatic test_tuning;
    for (int i = 0; i < 4; i++) i_host.wr(8'h54 + 8'(i), 8'h12 << i);
    check("staged", FREQ_WORD, 0);
    i_host.rd(ntcr_pkg::ADDR_TW3, r);
    check("tw3", r, 8'h90);
    i_host.wr(ntcr_pkg::ADDR_MODCTL, 8'h04);
    check("freq", FREQ_WORD, 32'h9048_2412);
    i_host.rd(ntcr_pkg::ADDR_MODCTL, r);
    check("tune ack", r, 8'h0C);
    i_host.wr(ntcr_pkg::ADDR_TW0, 8'hA5);
    i_host.wr(ntcr_pkg::ADDR_MODCTL, 8'h04);
    check("no edge", FREQ_WORD, 32'h9048_2412);
    i_host.tune(32'hDEAD_BEEF);
    check("retune", FREQ_WORD, 32'hDEAD_BEEF);
  endtask
  task automatic test_phase_side;
    i_host.wr(ntcr_pkg::ADDR_PHASEH, 8'h80);
    i_host.wr(ntcr_pkg::ADDR_PHASEL, 8'h01);
    check("phase", PHASE_OFFSET, 16'h8001);
    i_host.wr(ntcr_pkg::ADDR_MODCTL, 8'h81);
    check("mode on", {BYPASS, SIDEBAND}, 2'b11);
    i_host.wr(ntcr_pkg::ADDR_MODCTL, 8'h00);
    check("mode off", {BYPASS, SIDEBAND}, 2'b00);
  endtask
  // strobe without arm is ignored; armed, only the first strobe resets
  task automatic test_frame;
    FRAME_EXT = 1'b1;
    repeat (2) @(posedge CLK);
    #1;
    FRAME_EXT = 1'b0;
    check("unarmed", NCO_RESET, 0);
    i_host.wr(ntcr_pkg::ADDR_MODCTL, 8'h10);
    @(posedge CLK);
    #1;
    FRAME_EXT = 1'b1;
    @(posedge CLK);
    #1;
    check("nco reset", NCO_RESET, 1);
    @(posedge CLK);
    #1;
    FRAME_EXT = 1'b0;
    check("second strobe", NCO_RESET, 0);
    i_host.rd(ntcr_pkg::ADDR_MODCTL, r);
    check("frame ack", r, 8'h38);
    i_host.wr(ntcr_pkg::ADDR_MODCTL, 8'h00);
    i_host.wr(ntcr_pkg::ADDR_MODCTL, 8'h10);
    i_host.wr(ntcr_pkg::ADDR_MODCTL, 8'h00);
    FRAME_EXT = 1'b1;
    @(posedge CLK);
    #1;
    FRAME_EXT = 1'b0;
    check("cancelled arm", NCO_RESET, 0);
    i_host.wr(ntcr_pkg::ADDR_MODCTL, 8'h10);
    FRAME_EXT = 1'b1;
    @(posedge CLK);
    #1;
    FRAME_EXT = 1'b0;
    check("re-armed", NCO_RESET, 1);
  endtask
  // a mid-run reset clears the sticky acknowledges and the active word
  task automatic test_rerun;
    RST = 1'b1;
    @(posedge CLK);
    #1;
    RST = 1'b0;
    check("word cleared", FREQ_WORD, 0);
    i_host.rd(ntcr_pkg::ADDR_MODCTL, r);
    check("acks cleared", r, 8'h80);
  endtask
  initial begin
    repeat (10) @(posedge CLK);
    #1;
    RST = 1'b0;
    test_reset();
    test_tuning();
    test_phase_side();
    test_frame();
    test_rerun();
    report_and_stop();
  end
endmodule
`default_nettype wire
